// ==== sdb_baud_gen.sv ====
// Module: cascaded prescaler and rate divider producing the line-rate tick
module sdb_baud_gen
  import sdb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Divider selects
  input wire logic [1:0] pre_sel_i,
  input wire logic [2:0] rate_sel_i,
  // Ticks
  output logic x16_tick_o,
  output logic bit_tick_o
);

  // ==========================================================================
  // Prescaler stage
  // ==========================================================================
  function automatic logic [3:0] prescale_divisor_of(input logic [1:0] s);
    case (s)
      2'b00: prescale_divisor_of = SDB_PRE_DIV_0;
      2'b01: prescale_divisor_of = SDB_PRE_DIV_1;
      2'b10: prescale_divisor_of = SDB_PRE_DIV_2;
      default: prescale_divisor_of = SDB_PRE_DIV_3;
    endcase
  endfunction : prescale_divisor_of

  logic [3:0] pre_cnt_reg;
  logic [3:0] prescale_divisor_reg;
  logic [6:0] rate_cnt_reg;
  logic [6:0] rate_divisor_m1_reg;
  logic [1:0] div4_cnt_reg;
  logic [3:0] div16_cnt_reg;
  logic pre_tick;
  logic rate_tick;
  logic x4_tick;

  assign pre_tick = (pre_cnt_reg == prescale_divisor_reg - 4'h1);
  assign rate_tick = pre_tick && (rate_cnt_reg == rate_divisor_m1_reg);
  assign x4_tick = rate_tick && (div4_cnt_reg == 2'h3);

  // Divisors are latched only at a period boundary, so a change
  // never truncates the running period
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prescale_divisor_reg <= SDB_PRE_DIV_0;
      rate_divisor_m1_reg <= 7'h00;
    end else if (rate_tick) begin
      prescale_divisor_reg <= prescale_divisor_of(pre_sel_i);
      rate_divisor_m1_reg <= 7'((8'h01 << rate_sel_i) - 8'h01);
    end
  end

  // Prescaler count
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || pre_tick) begin
      pre_cnt_reg <= 4'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end
  end

  // Rate count, advances once per prescaler period
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || rate_tick) begin
      rate_cnt_reg <= 7'h00;
    end else if (pre_tick) begin
      rate_cnt_reg <= rate_cnt_reg + 7'h01;
    end
  end

  // Fixed divide by 64: 4 for the x16 sample clock, then 16 for the bit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div4_cnt_reg <= 2'h0;
      div16_cnt_reg <= 4'h0;
      x16_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else begin
      if (rate_tick) begin
        div4_cnt_reg <= div4_cnt_reg + 2'h1;
      end
      if (x4_tick) begin
        div16_cnt_reg <= div16_cnt_reg + 4'h1;
      end
      x16_tick_o <= x4_tick;
      bit_tick_o <= x4_tick && (div16_cnt_reg == 4'hF);
    end
  end

  // Latch checks use the widest selects, where a slip shows most
  chk_pre_latch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rate_tick && pre_sel_i == 2'b11 |=> prescale_divisor_reg == SDB_PRE_DIV_3)
    else $error("prescale divisor not latched");

  chk_rate_latch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rate_tick && rate_sel_i == 3'h7 |=> rate_divisor_m1_reg == 7'h7F)
    else $error("rate divisor not latched");

endmodule : sdb_baud_gen

// ==== sdb_core.sv ====
// Module: serial data buffer, baud select register and flag logic
module sdb_core
  import sdb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Internal bus
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // Receive shift register side
  input wire logic rx_load_i,
  input wire logic [7:0] rx_byte_i,
  // Transmit shift register side
  input wire logic tx_take_i,
  output logic [7:0] tx_byte_o,
  output logic tx_pending_o,
  // Shared rate ticks
  output logic x16_tick_o,
  output logic bit_tick_o,
  // Flags
  output logic tx_buffer_empty_flag_o,
  output logic rx_full_flag_o,
  output logic overrun_flag_o
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] received_byte_reg;
  logic [7:0] transmit_byte_reg;
  logic [7:0] baud_select_reg;
  logic tx_pending_reg;
  logic txe_reg;
  logic rxf_reg;
  logic ovr_reg;
  logic txe_armed_reg;
  logic rxf_armed_reg;
  logic ovr_armed_reg;

  logic hit_data;
  logic hit_baud;
  logic hit_stat;
  logic data_rd;
  logic data_wr;
  logic stat_rd;
  logic rx_overrun;

  assign hit_data = (bus_addr_i == SDB_ADDR_DATA);
  assign hit_baud = (bus_addr_i == SDB_ADDR_BAUD);
  assign hit_stat = (bus_addr_i == SDB_ADDR_STAT);
  assign data_rd = bus_rd_i && hit_data;
  assign data_wr = bus_wr_i && hit_data;
  assign stat_rd = bus_rd_i && hit_stat;
  assign rx_overrun = rx_load_i && rxf_reg && !(rxf_armed_reg && data_rd);

  // Received byte has no reset; a load while full, unless an armed data read empties it that cycle, is dropped so the
  // unread byte survives an overrun
  always_ff @(posedge ref_clk_i) begin
    if (rx_load_i && !rx_overrun) begin
      received_byte_reg <= rx_byte_i;
    end
  end

  // Transmit byte has no reset either
  always_ff @(posedge ref_clk_i) begin
    if (data_wr) begin
      transmit_byte_reg <= bus_wdata_i;
    end
  end

  // Pending marks a written byte not yet moved to the shift register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_pending_reg <= 1'b0;
    end else if (data_wr) begin
      tx_pending_reg <= 1'b1;
    end else if (tx_take_i) begin
      tx_pending_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Baud select register
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      baud_select_reg <= SDB_BAUD_RST;
    end else if (bus_wr_i && hit_baud) begin
      baud_select_reg <= bus_wdata_i & SDB_BAUD_MASK;
    end
  end

  // One generator serves both directions
  sdb_baud_gen u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pre_sel_i(baud_select_reg[SDB_PRE_LSB +: 2]),
    .rate_sel_i(baud_select_reg[SDB_RATE_LSB +: 3]),
    .x16_tick_o(x16_tick_o),
    .bit_tick_o(bit_tick_o)
  );

  // ==========================================================================
  // Flags and two-step clear sequences
  // ==========================================================================
  // Arming happens on a status read that sees the flag set; any other
  // status read re-samples it, so a stale arm cannot clear a new flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      txe_armed_reg <= 1'b0;
      rxf_armed_reg <= 1'b0;
      ovr_armed_reg <= 1'b0;
    end else begin
      if (stat_rd) begin
        txe_armed_reg <= txe_reg;
      end else if (data_wr) begin
        txe_armed_reg <= 1'b0;
      end
      if (stat_rd) begin
        rxf_armed_reg <= rxf_reg;
        ovr_armed_reg <= ovr_reg;
      end else if (data_rd) begin
        rxf_armed_reg <= 1'b0;
        ovr_armed_reg <= 1'b0;
      end
    end
  end

  // Set wins over clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      txe_reg <= SDB_TXE_RST;
    end else if (tx_take_i && tx_pending_reg) begin
      txe_reg <= 1'b1;
    end else if (txe_armed_reg && data_wr) begin
      txe_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rxf_reg <= SDB_RXF_RST;
    end else if (rx_load_i) begin
      rxf_reg <= 1'b1;
    end else if (rxf_armed_reg && data_rd) begin
      rxf_reg <= 1'b0;
    end
  end

  // A data read without the armed status read never clears overrun
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ovr_reg <= SDB_OVR_RST;
    end else if (rx_overrun) begin
      ovr_reg <= 1'b1;
    end else if (ovr_armed_reg && data_rd) begin
      ovr_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data and registered outputs
  // ==========================================================================
  // Data reads see only the received byte, so software must not
  // read-modify-write this address
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      if (hit_data) begin
        bus_rdata_o <= received_byte_reg;
      end else if (hit_baud) begin
        bus_rdata_o <= baud_select_reg;
      end else if (hit_stat) begin
        bus_rdata_o <= 8'h00;
        bus_rdata_o[SDB_ST_TXE] <= txe_reg;
        bus_rdata_o[SDB_ST_RXF] <= rxf_reg;
        bus_rdata_o[SDB_ST_OVR] <= ovr_reg;
      end else begin
        bus_rdata_o <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_byte_o <= 8'h00;
      tx_pending_o <= 1'b0;
      tx_buffer_empty_flag_o <= SDB_TXE_RST;
      rx_full_flag_o <= SDB_RXF_RST;
      overrun_flag_o <= SDB_OVR_RST;
    end else begin
      tx_byte_o <= transmit_byte_reg;
      tx_pending_o <= tx_pending_reg;
      tx_buffer_empty_flag_o <= txe_reg;
      rx_full_flag_o <= rxf_reg;
      overrun_flag_o <= ovr_reg;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_baud_reset: assert property (@(posedge ref_clk_i)
    rst_i |=> baud_select_reg == SDB_BAUD_RST)
    else $error("baud select not cleared by reset");

  chk_rate_reset: assert property (@(posedge ref_clk_i)
    rst_i |=> baud_select_reg[SDB_RATE_LSB +: 3] == 3'h0)
    else $error("rate select not cleared by reset");

  chk_rx_capture: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_load_i && !rxf_reg |=> received_byte_reg == $past(rx_byte_i))
    else $error("received byte not captured");

  chk_tx_capture: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    data_wr |=> ##1 tx_byte_o == $past(bus_wdata_i, 2))
    else $error("transmit byte not captured");

  chk_data_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    data_rd |=> bus_rdata_o == $past(received_byte_reg))
    else $error("data read returned wrong byte");

  chk_rxf_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rxf_reg && !rxf_armed_reg && !rx_load_i |=> rxf_reg)
    else $error("rx full cleared without status read");

  chk_ovr_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ovr_reg && !(ovr_armed_reg && data_rd) |=> ovr_reg)
    else $error("overrun cleared without sequence");

  chk_txe_clear: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    txe_reg && txe_armed_reg && data_wr && !(tx_take_i && tx_pending_reg)
      |=> !txe_reg ##1 !tx_buffer_empty_flag_o)
    else $error("tx empty not cleared by sequence");

  chk_rx_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_overrun |=> received_byte_reg == $past(received_byte_reg))
    else $error("overrun disturbed held byte");

  // Only checked once a byte is known to be held, so power-up X is skipped
  chk_buf_reset: assert property (
    @(posedge ref_clk_i)
    rst_i && rxf_reg && !rx_load_i
      |=> received_byte_reg == $past(received_byte_reg))
    else $error("reset disturbed received byte");

  chk_rxf_set: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_load_i |=> rxf_reg)
    else $error("rx full not set by load");

  chk_rxf_seq: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rxf_armed_reg && data_rd && !rx_load_i |=> !rxf_reg)
    else $error("rx full not cleared by sequence");

  chk_ovr_set: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_load_i && rxf_reg && !(rxf_armed_reg && data_rd)
      |=> ovr_reg && received_byte_reg == $past(received_byte_reg))
    else $error("overrun not flagged");

  chk_ovr_seq: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ovr_armed_reg && data_rd && !rx_load_i |=> !ovr_reg)
    else $error("overrun not cleared by sequence");

  chk_txe_set: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    tx_take_i && tx_pending_reg && !data_wr |=> txe_reg && !tx_pending_reg)
    else $error("tx empty not set by transfer");

  chk_txe_keep: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    txe_reg && !(txe_armed_reg && data_wr) |=> txe_reg)
    else $error("tx empty cleared without sequence");

  chk_stat_read: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    stat_rd |=> bus_rdata_o[SDB_ST_TXE] == $past(txe_reg)
      && bus_rdata_o[SDB_ST_RXF] == $past(rxf_reg)
      && bus_rdata_o[SDB_ST_OVR] == $past(ovr_reg))
    else $error("status read returned wrong flags");

  chk_rdata_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data changed without a read");

  chk_pend_out: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    data_wr |=> ##1 tx_pending_o)
    else $error("written byte not shown pending");

  chk_baud_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    bus_wr_i && hit_baud
      |=> baud_select_reg == ($past(bus_wdata_i) & SDB_BAUD_MASK))
    else $error("baud select write not stored");

endmodule : sdb_core

// ==== sdb_line_model.sv ====
// File: shift register side model feeding and draining the data buffer
module sdb_line_model (
  // Clock
  input wire logic ref_clk_i,
  // Shift register handshakes
  output logic rx_load_o,
  output logic [7:0] rx_byte_o,
  output logic tx_take_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: strobes low, byte lines never left showing a stale value
  initial begin
    rx_load_o = 1'b0;
    rx_byte_o = 8'hA5;
    tx_take_o = 1'b0;
  end
  // Receive shift register hands over one whole byte
  task automatic deliver(input logic [7:0] b);
    @(negedge ref_clk_i);
    rx_load_o = 1'b1;
    rx_byte_o = b;
    @(negedge ref_clk_i);
    rx_load_o = 1'b0;
    rx_byte_o = ~b;
  endtask : deliver
  // Transmit shift register pulls the held byte
  task automatic take();
    @(negedge ref_clk_i);
    tx_take_o = 1'b1;
    @(negedge ref_clk_i);
    tx_take_o = 1'b0;
  endtask : take
endmodule : sdb_line_model

// ==== sdb_pkg.sv ====
// Package: register map, field layout and constants of the serial data and baud block
package sdb_pkg;

  // ==========================================================================
  // Register map (internal bus byte addresses)
  // ==========================================================================
  localparam logic [15:0] SDB_ADDR_DATA = 16'h0018;
  localparam logic [15:0] SDB_ADDR_BAUD = 16'h0019;
  localparam logic [15:0] SDB_ADDR_STAT = 16'h0016;

  // ==========================================================================
  // Baud select fields and reset value
  // ==========================================================================
  localparam int SDB_PRE_LSB = 4;
  localparam int SDB_RATE_LSB = 0;
  localparam logic [7:0] SDB_BAUD_RST = 8'h00;
  localparam logic [7:0] SDB_BAUD_MASK = 8'h37;

  // ==========================================================================
  // Status bit positions and reset values
  // ==========================================================================
  localparam int SDB_ST_TXE = 7;
  localparam int SDB_ST_RXF = 5;
  localparam int SDB_ST_OVR = 3;
  localparam logic SDB_TXE_RST = 1'b1;
  localparam logic SDB_RXF_RST = 1'b0;
  localparam logic SDB_OVR_RST = 1'b0;

  // ==========================================================================
  // Divider constants
  // ==========================================================================
  localparam int SDB_OVERSAMPLE = 64;
  localparam logic [3:0] SDB_PRE_DIV_0 = 4'h1;
  localparam logic [3:0] SDB_PRE_DIV_1 = 4'h3;
  localparam logic [3:0] SDB_PRE_DIV_2 = 4'h4;
  localparam logic [3:0] SDB_PRE_DIV_3 = 4'hD;

endpackage : sdb_pkg

// ==== serial_data_and_baud_gen_tb_top.sv ====
// File: self-checking bench for the data buffer and baud generator
module serial_data_and_baud_gen_tb_top
  import sdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_i, bus_rd_i, bus_wr_i, rx_load_i, tx_take_i;
  logic [15:0] bus_addr_i;
  logic [7:0] bus_wdata_i, bus_rdata_o, rx_byte_i, tx_byte_o, b;
  logic tx_pending_o, x16_tick_o, bit_tick_o, txe_o, rxf_o, ovr_o;
  int err_total, checks_done, cyc, seed;
  bit e_txe, e_rxf, e_ovr, a_txe, a_rxf, a_ovr, e_pend;
  logic [7:0] e_rx, e_tx, e_baud;
  // ==========================================================
  // Clock, design and line model
  // ==========================================================
  always #2 ref_clk_i = ~ref_clk_i;
  sdb_core i_sdb_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .rx_load_i(rx_load_i), .rx_byte_i(rx_byte_i), .tx_take_i(tx_take_i),
    .tx_byte_o(tx_byte_o), .tx_pending_o(tx_pending_o),
    .x16_tick_o(x16_tick_o), .bit_tick_o(bit_tick_o),
    .tx_buffer_empty_flag_o(txe_o), .rx_full_flag_o(rxf_o),
    .overrun_flag_o(ovr_o));
  sdb_line_model i_sdb_line_model (.ref_clk_i(ref_clk_i),
    .rx_load_o(rx_load_i), .rx_byte_o(rx_byte_i), .tx_take_o(tx_take_i));
  // Hang guard: longest baud sweep fits well inside this
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  // ==========================================================
  // Compare, verdict and model-driven bus tasks
  // ==========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("err_total=%0d checks_done=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic flags();
    chk({13'h0, txe_o, rxf_o, ovr_o}, {13'h0, e_txe, e_rxf, e_ovr});
    chk({15'h0, tx_pending_o}, {15'h0, e_pend});
  endtask : flags
  // One bus access; read data and flags settle two cycles later
  task automatic acc(input bit w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk_i);
    bus_addr_i = a;
    bus_wr_i = w;
    bus_rd_i = !w;
    bus_wdata_i = d;
    @(negedge ref_clk_i);
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    bus_addr_i = 16'hFFFF;
    repeat (2) @(negedge ref_clk_i);
    if (!w && a == SDB_ADDR_STAT) begin
      chk({8'h0, bus_rdata_o}, {8'h0, e_txe, 1'b0, e_rxf, 1'b0, e_ovr, 3'h0});
      a_txe = e_txe;
      a_rxf = e_rxf;
      a_ovr = e_ovr;
    end else if (!w && a == SDB_ADDR_DATA) begin
      chk({8'h0, bus_rdata_o}, {8'h0, e_rx});
      e_rxf = e_rxf && !a_rxf;
      e_ovr = e_ovr && !a_ovr;
      a_rxf = 1'b0;
      a_ovr = 1'b0;
    end else if (!w) begin
      chk({8'h0, bus_rdata_o}, a == SDB_ADDR_BAUD ? {8'h0, e_baud} : 16'h0);
    end else if (a == SDB_ADDR_DATA) begin
      e_txe = e_txe && !a_txe;
      a_txe = 1'b0;
      e_tx = d;
      e_pend = 1'b1;
      chk({8'h0, tx_byte_o}, {8'h0, e_tx});
    end else if (a == SDB_ADDR_BAUD) begin
      e_baud = d & SDB_BAUD_MASK;
    end
    flags();
  endtask : acc
  task automatic rx(input logic [7:0] v);
    i_sdb_line_model.deliver(v);
    repeat (2) @(negedge ref_clk_i);
    if (e_rxf) begin
      e_ovr = 1'b1;
    end else begin
      e_rx = v;
      e_rxf = 1'b1;
    end
    flags();
  endtask : rx
  task automatic tx();
    i_sdb_line_model.take();
    repeat (2) @(negedge ref_clk_i);
    e_txe = e_txe || e_pend;
    e_pend = 1'b0;
    flags();
  endtask : tx
  task automatic do_rst();
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    {e_txe, e_rxf, e_ovr, a_txe, a_rxf, a_ovr, e_pend} = 7'h40;
    e_baud = 8'h00;
    flags();
  endtask : do_rst
  task automatic gap(input bit fine, output int n);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while ((fine ? x16_tick_o : bit_tick_o) !== 1'b1 && n < 20000);
  endtask : gap
  // New select is only promised from the period after the next tick
  task automatic baud(input int p, input int r);
    int n;
    int presc;
    presc = p == 0 ? 1 : p == 1 ? 3 : p == 2 ? 4 : 13;
    acc(1, SDB_ADDR_BAUD, 8'(p * 16 + r));
    gap(1'b0, n);
    gap(1'b0, n);
    chk(16'(n), 16'(64 * presc * (1 << r)));
    gap(1'b1, n);
    gap(1'b1, n);
    chk(16'(n), 16'(4 * presc * (1 << r)));
  endtask : baud
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {ref_clk_i, rst_i, bus_rd_i, bus_wr_i} = 4'h4;
    bus_addr_i = 16'hFFFF;
    bus_wdata_i = 8'h00;
    seed = 43061;
    do_rst();
    acc(0, SDB_ADDR_BAUD, 8'h00);
    rx(8'($random(seed)));
    acc(0, SDB_ADDR_DATA, 8'h00);
    acc(0, SDB_ADDR_STAT, 8'h00);
    acc(0, SDB_ADDR_DATA, 8'h00);
    rx(8'($random(seed)));
    rx(8'($random(seed)));
    acc(0, SDB_ADDR_DATA, 8'h00);
    acc(0, SDB_ADDR_STAT, 8'h00);
    acc(0, SDB_ADDR_DATA, 8'h00);
    rx(8'($random(seed)));
    do_rst();
    acc(0, SDB_ADDR_DATA, 8'h00);
    acc(1, SDB_ADDR_DATA, 8'($random(seed)));
    acc(0, SDB_ADDR_DATA, 8'h00);
    acc(0, SDB_ADDR_STAT, 8'h00);
    acc(1, SDB_ADDR_DATA, 8'($random(seed)));
    tx();
    acc(1, SDB_ADDR_STAT, 8'hFF);
    acc(1, 16'h0017, 8'hFF);
    acc(0, 16'h0017, 8'h00);
    acc(0, SDB_ADDR_STAT, 8'h00);
    repeat (4) begin
      acc(1, SDB_ADDR_BAUD, 8'($random(seed)));
      acc(0, SDB_ADDR_BAUD, 8'h00);
    end
    for (int p = 0; p < 4; p++) baud(p, 0);
    for (int r = 0; r < 8; r++) baud(0, r);
    baud(3, 1);
    wrap_up();
  end
endmodule : serial_data_and_baud_gen_tb_top
